//--- logic/prpc_ref_div.sv
/*
 Reference input divider: a counter of ref_edge pulses whose taps give /2, /4, /8.
 Assumes the reference is sampled on ref_clk and already synchronised.
*/
`include "prpc_map.svh"
`default_nettype none
module prpc_ref_div (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic div_rst,
  input wire logic ref_edge,
  input wire prpc_pkg::prpc_div_t ratio,
  output logic div_out
);
  import prpc_pkg::*;
  logic [`PRPC_DIV_CNT_W-1:0] cnt_q;
  logic tap;
  always_ff @(posedge ref_clk) begin
    if (rst || div_rst) begin
      cnt_q <= '0;
    end else if (ref_edge) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
  // Tap per ratio; 00 holds the tap at 0, and prpc_top takes the bypass path itself
  assign tap = (ratio == 2'h1) ? cnt_q[0] :
               (ratio == 2'h2) ? cnt_q[1] :
               (ratio == 2'h3) ? cnt_q[2] : 1'b0;
  always_ff @(posedge ref_clk) begin
    if (rst || div_rst) begin
      div_out <= 1'b0;
    end else begin
      div_out <= tap;
    end
  end
endmodule
`default_nettype wire

//--- logic/prpc_top.sv
/*
 Reference-path configuration word with AHB-Lite slave and path steering.
 Assumes a single master, single word transfers, and an external reference
 level arriving asynchronously on ref_in.
*/
// Chosen here: register access over AHB-Lite.
`include "prpc_map.svh"
`default_nettype none
module prpc_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ref_in,
  output logic pll_enable,
  output logic sysclk_from_pll,
  output logic [7:0] fb_div_n,
  output logic [8:0] fb_mult_total,
  output logic [3:0] pll_path,
  output logic ref_falling,
  output logic div_held,
  output logic pll_ref
);
  import prpc_pkg::*;
  logic [31:0] cfg_q, cfg_d;
  logic wr_pend_q, rd_pend_q;
  logic [7:0] addr_q;
  logic [31:0] rdata_d;
  logic ref_s1_q, ref_s2_q, ref_s3_q;
  logic div_tick;
  prpc_path_e path_d;
  logic ref_sel_d;
  wire addr_ph = hsel && hready && htrans[1];
  wire hit_cfg = (addr_q == `PRPC_CFG_ADDR);
  wire hit_stat = (addr_q == `PRPC_STAT_ADDR);
  wire en = cfg_q[`PRPC_EN_BIT];
  wire divsel = cfg_q[`PRPC_DIVSEL_BIT];
  wire dbl = cfg_q[`PRPC_DBL_BIT];
  wire edge_sel = cfg_q[`PRPC_EDGE_BIT];
  wire rise_ev = ref_s2_q && !ref_s3_q;
  wire fall_ev = !ref_s2_q && ref_s3_q;
  // Masked write keeps the top bits at zero
  assign cfg_d = (wr_pend_q && hit_cfg) ? (hwdata & `PRPC_WMASK) : cfg_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_q <= `PRPC_CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ph && hwrite;
      rd_pend_q <= addr_ph && !hwrite;
      addr_q <= addr_ph ? haddr : addr_q;
    end
  end
  // Read mux; unmapped addresses read zero, response always OKAY
  wire [31:0] stat_word = {28'h0000000, pll_path};
  always_comb begin
    if (hit_cfg) begin
      rdata_d = cfg_q;
    end else if (hit_stat) begin
      rdata_d = stat_word;
    end else begin
      rdata_d = 32'h00000000;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= (addr_ph && !hwrite) ? 32'h00000000 : (rd_pend_q ? rdata_d : hrdata);
      hreadyout <= !(addr_ph && !hwrite);
      hresp <= 1'b0;
    end
  end
  // Read needs one wait state so hrdata comes from a flop
  // Reference level crosses into ref_clk; s1 feeds only s2
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
    end else begin
      ref_s1_q <= ref_in;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
    end
  end
  prpc_ref_div u_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .div_rst(cfg_q[`PRPC_DIVRST_BIT]),
    .ref_edge(rise_ev),
    .ratio(cfg_q[`PRPC_DIV_HI:`PRPC_DIV_LO]),
    .div_out(div_tick)
  );
  // Path steering; selections only matter with the PLL enabled
  always_comb begin
    if (!en) begin
      path_d = PRPC_OFF;
    end else if (divsel) begin
      path_d = PRPC_DIVIDE;
    end else if (dbl) begin
      path_d = PRPC_DOUBLE;
    end else begin
      path_d = PRPC_THRU;
    end
  end
  wire bypass = (cfg_q[`PRPC_DIV_HI:`PRPC_DIV_LO] == 2'h0);
  always_comb begin
    case (path_d)
      PRPC_DIVIDE: ref_sel_d = bypass ? ref_s2_q : div_tick;
      PRPC_DOUBLE: ref_sel_d = rise_ev || fall_ev;
      PRPC_THRU: ref_sel_d = edge_sel ? !ref_s2_q : ref_s2_q;
      default: ref_sel_d = 1'b0;
    endcase
  end
  wire [8:0] mult = {cfg_q[`PRPC_N_HI:`PRPC_N_LO], 1'b0};
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pll_enable <= 1'b0;
      sysclk_from_pll <= 1'b0;
      fb_div_n <= `PRPC_N_RESET;
      fb_mult_total <= {`PRPC_N_RESET, 1'b0};
      pll_path <= PRPC_OFF;
      ref_falling <= 1'b0;
      div_held <= 1'b0;
      pll_ref <= 1'b0;
    end else begin
      pll_enable <= en;
      sysclk_from_pll <= en;
      fb_div_n <= cfg_q[`PRPC_N_HI:`PRPC_N_LO];
      fb_mult_total <= mult;
      pll_path <= path_d;
      ref_falling <= (path_d == PRPC_THRU) && edge_sel;
      div_held <= cfg_q[`PRPC_DIVRST_BIT];
      pll_ref <= ref_sel_d;
    end
  end
endmodule
`default_nettype wire

//--- pkg/prpc_map.svh
/*
 Register map and field layout of the reference-path configuration word.
 Assumes an AHB-Lite slave with one aligned 32-bit word per register.
*/
// Overview of operation
// - Writing 1 to bit 22 holds the reference input divider in reset; 0 lets it run.
// - Field [21:20] sets the input division: bypass, divide by 2, 4 or 8.
// - The divider ratio reaches the PLL reference only when bit 17 is 1.
// - Bit 19 picks the feedthrough path (0) or doubler path (1) when enabled and bit 17 is 0.
// - Bit 18 enables the PLL, whose output then becomes the system clock.
// - Bit 17 picks feedthrough/doubler (0) or divider path (1), only while enabled.
// - Bit 16 picks rising (0) or falling (1) reference edge on the plain feedthrough path.
// - Field [15:8] holds N; the fixed halving in the feedback makes the multiplication 2N.
// - After reset N is 25, a multiplication of 50.
`ifndef PRPC_MAP_SVH
`define PRPC_MAP_SVH
`define PRPC_CFG_INDEX 8'h02
`define PRPC_CFG_ADDR 8'h08
`define PRPC_STAT_ADDR 8'h0c
`define PRPC_DIVRST_BIT 22
`define PRPC_DIV_HI 21
`define PRPC_DIV_LO 20
`define PRPC_DBL_BIT 19
`define PRPC_EN_BIT 18
`define PRPC_DIVSEL_BIT 17
`define PRPC_EDGE_BIT 16
`define PRPC_N_HI 15
`define PRPC_N_LO 8
`define PRPC_N_RESET 8'h19
`define PRPC_WMASK 32'h007fff00
`define PRPC_CFG_RESET 32'h00001900
`define PRPC_DIV_CNT_W 3
`endif

//--- pkg/prpc_pkg.sv
/*
 Types for the reference-path configuration block.
 Assumes the map header is on the include path.
*/
`default_nettype none
package prpc_pkg;
  typedef enum logic [3:0] {
    PRPC_OFF = 4'h1,
    PRPC_THRU = 4'h2,
    PRPC_DOUBLE = 4'h4,
    PRPC_DIVIDE = 4'h8
  } prpc_path_e;
  typedef logic [1:0] prpc_div_t;
endpackage
`default_nettype wire

//--- testbench/pll_ref_path_config_bench.sv
/* Self-checking bench for prpc_top.
   Assumes the monitor and reference source are compiled first. */
`default_nettype none
module pll_ref_path_config_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, ref_in, pll_enable, sysclk_from_pll, ref_falling, div_held, pll_ref;
  logic [7:0] fb_div_n;
  logic [8:0] fb_mult_total;
  logic [3:0] pll_path;
  logic [31:0] cfg_tab [4] = '{32'h00000a00, 32'h00050a00, 32'h000d0a00, 32'h00370a00};
  logic [3:0] path_tab [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
  logic edge_tab [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  int n_mismatch = 0;
  int tests_run = 0;
  always #20 ref_clk = ~ref_clk;
  prpc_ref_src SRC (.ref_out(ref_in));
  prpc_top DUT (.hready(hreadyout), .hsize(3'h2), .*);
  task automatic check(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wait_ready;
    for (int i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (hreadyout === 1'b1) return;
    end
    n_mismatch++;
    end_of_test();
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    hwrite <= wr;
    haddr <= a;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    bus(1'b0, 8'h08, 32'h0);
    check("reset word", rd, 32'h00001900);
    bus(1'b1, 8'h08, 32'hffffffff);
    bus(1'b0, 8'h08, 32'h0);
    check("masked word", rd, 32'h007fff00);
    check("div held", {31'h0, div_held}, 32'h1);
    check("mult max", {23'h0, fb_mult_total}, 32'h1fe);
    foreach (cfg_tab[i]) begin
      bus(1'b1, 8'h08, cfg_tab[i]);
      bus(1'b0, 8'h0c, 32'h0);
      check("path", rd, {28'h0, path_tab[i]});
      check("edge", {31'h0, ref_falling}, {31'h0, edge_tab[i]});
      check("n", {24'h0, fb_div_n}, 32'h0a);
      check("enable", {31'h0, pll_enable}, {31'h0, path_tab[i] != 4'h1});
      check("sysclk", {31'h0, sysclk_from_pll}, {31'h0, path_tab[i] != 4'h1});
    end
    // A write to status must leave the config word alone; unmapped places read zero
    bus(1'b1, 8'h0c, 32'hffffffff);
    bus(1'b0, 8'h08, 32'h0);
    check("status write", rd, 32'h00370a00);
    bus(1'b0, 8'h10, 32'h0);
    check("unmapped", rd, 32'h0);
    end_of_test();
  end
endmodule
bind prpc_top prpc_monitor MON (.*);
`default_nettype wire

//--- testbench/prpc_monitor.sv
/* Port checker for prpc_top.
   Assumes a bind by name from the bench. */
`default_nettype none
module prpc_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic pll_enable,
  input wire logic sysclk_from_pll,
  input wire logic [7:0] fb_div_n,
  input wire logic [8:0] fb_mult_total,
  input wire logic [3:0] pll_path,
  input wire logic ref_falling,
  input wire logic pll_ref
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_sysclk_follow: assert property (sysclk_from_pll == pll_enable)
    else $error("sysclk select off");
  chk_mult_double: assert property (fb_mult_total == {fb_div_n, 1'b0})
    else $error("bad multiplication");
  chk_path_off: assert property (!pll_enable |-> pll_path == 4'h1)
    else $error("path while disabled");
  chk_path_onehot: assert property ($onehot(pll_path))
    else $error("path not one-hot");
  chk_edge_thru: assert property (ref_falling |-> pll_path == 4'h2)
    else $error("edge off feedthrough");
  chk_reset_n: assert property ($fell(rst) |-> fb_mult_total == 9'h032)
    else $error("bad reset N");
  chk_reserved_zero: assert property ($rose(hreadyout) |-> hrdata[31:23] == 9'h000)
    else $error("reserved bits set");
  chk_wait_once: assert property (!hreadyout |=> hreadyout)
    else $error("wait too long");
  chk_okay_only: assert property (hresp == 1'b0)
    else $error("error response");
  chk_ref_off: assert property (pll_path == 4'h1 |-> !pll_ref)
    else $error("reference while disabled");
  cover property (pll_path == 4'h8);
  cover property (ref_falling);
  cover property ($rose(hreadyout));
endmodule
`default_nettype wire

//--- testbench/prpc_ref_src.sv
/* External reference clock source.
   Free running, phase unrelated to ref_clk. */
`default_nettype none
module prpc_ref_src (
  output logic ref_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ref_out = 1'b0;
    forever #67 ref_out = ~ref_out;
  end
endmodule
`default_nettype wire
